// File: pmcb_far_model.sv
// far-side model: push button with pull-up and the two mode-select pins
`timescale 1ns/100ps
`default_nettype none
module pmcb_far_model (
    // pins toward the block
    output logic button_n,
    output logic mode_pin_lo,
    output logic mode_pin_hi
);
    // pull-up keeps the button high until someone presses it
    initial begin
        button_n = 1'b1;
        mode_pin_lo = 1'b0;
        mode_pin_hi = 1'b0;
    end
    // called just after a clock edge; a press holds the pin low
    task automatic set_button(input logic pressed);
        button_n = ~pressed;
    endtask : set_button
    // pin levels pick a mode setting, hi pin is the upper bit
    task automatic set_pins(input logic [1:0] mode);
        {mode_pin_hi, mode_pin_lo} = mode;
    endtask : set_pins
endmodule : pmcb_far_model
`default_nettype wire

// File: pmcb_map.svh
// constants for the mode and button control block
`ifndef PMCB_MAP_SVH
`define PMCB_MAP_SVH
`define PMCB_SRC_GREATER 2'h0
`define PMCB_SRC_BATT 2'h1
`define PMCB_SRC_INPUT 2'h2
`define PMCB_SRC_NONE 2'h3
`define PMCB_SRC_RESET 2'h0
`define PMCB_MODE_DEFAULT 2'h0
`define PMCB_DEGLITCH_US 200
`define PMCB_CLK_KHZ 10000
`define PMCB_DEGLITCH_CYC ((`PMCB_DEGLITCH_US * `PMCB_CLK_KHZ + 999) / 1000)
`define PMCB_LP_UNIT_S 4
`define PMCB_TICK_HZ 1000
`define PMCB_TICK_CYC (`PMCB_CLK_KHZ * 1000 / `PMCB_TICK_HZ)
`define PMCB_HOT_OFFSET_MV 140
`define PMCB_CV_STEP_MV 20
`define PMCB_HOT_OFFSET_CODE 6'h07
`define PMCB_RST_PULSE_CYC 16
`endif

// File: pmcb_pkg.sv
// types for the mode and button control block
package pmcb_pkg;
    typedef enum logic [2:0] {
        PMCB_ZONE_COLD,
        PMCB_ZONE_COOL,
        PMCB_ZONE_NORMAL,
        PMCB_ZONE_WARM,
        PMCB_ZONE_HOT
    } pmcb_zone_t;
    typedef enum logic [1:0] {
        PMCB_ST_IDLE,
        PMCB_ST_LOW,
        PMCB_ST_RESET
    } pmcb_btn_t;
endpackage : pmcb_pkg

// File: pmcb_top.sv
// mode setting, push-button, supply select and thermistor zone control
// Behaviour
// - select code: 00 greater-of, 01 battery, 10 input supply, 11 none
// - source select returns to greater-of on reset
// - two-bit prewarn threshold; event when system supply drops below it
// - button fall valid only after about 200us deglitch
// - in ship mode a filtered fall exits ship and starts in mode 0
// - falls during power-up or power-down sequencing are ignored
// - low beyond 4/8/12/16 s long press resets and recycles all rails
// - per-mode bit decides if a filtered fall returns to mode 0
// - filtered fall clears pin mode select enable of mode 0
// - zone charge control only while thermistor monitor enabled
// - four thresholds classify temperature into five zones
// - cold or hot: suspend charging and pause safety timer
// - cold-cool half current; cool-warm normal charging
// - warm-hot lowers charge voltage target by 140mV offset
// - four mode sets; mode 0 active after power-up
// - mode switch from button, mode pins or host writes
// - each mode holds rail enables, codes, ship enable, watchdog config
// - pin enable 0: host bits choose mode, pins ignored
`timescale 1ns/100ps
`default_nettype none
`include "pmcb_map.svh"
module pmcb_top
    import pmcb_pkg::*;
#(
    parameter int DEGLITCH_CYC = `PMCB_DEGLITCH_CYC,
    parameter int TICK_CYC = `PMCB_TICK_CYC,
    parameter int TICKS_PER_UNIT = `PMCB_LP_UNIT_S * `PMCB_TICK_HZ
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // pins from outside
    input wire logic button_n,
    input wire logic mode_pin_lo,
    input wire logic mode_pin_hi,
    // analog comparators
    input wire logic supply_below_warn,
    input wire logic ts_below_cold,
    input wire logic ts_below_cool,
    input wire logic ts_above_warm,
    input wire logic ts_above_hot,
    // sequencer status
    input wire logic seq_busy,
    input wire logic in_ship_mode,
    // configuration from the host register file
    input wire logic [1:0] supply_source_select,
    input wire logic [1:0] supply_prewarn_threshold,
    input wire logic [1:0] long_press_duration,
    input wire logic thermistor_monitor_enable,
    input wire logic [5:0] cv_target_code,
    input wire logic [1:0] host_mode_sel,
    input wire logic host_mode_wr,
    input wire logic [3:0] button_return_cfg,
    input wire logic pin_sel_en_wr,
    input wire logic pin_sel_en_wdata,
    // per mode: rail enables, 4 x 6 bit codes, ship enable, 2 bit watchdog
    input wire logic [4*4-1:0] mode_rail_en,
    input wire logic [4*24-1:0] mode_rail_code,
    input wire logic [3:0] mode_ship_en,
    input wire logic [4*2-1:0] mode_wdog_cfg,
    // outputs
    output logic [1:0] active_mode,
    output logic pin_mode_select_enable,
    output logic [1:0] source_path,
    output logic [1:0] prewarn_level,
    output logic prewarn_event,
    output logic ship_exit,
    output logic chip_reset_req,
    output logic button_valid,
    output logic charge_enable,
    output logic safety_timer_run,
    output logic charge_half,
    output logic [5:0] cv_effective,
    output logic [2:0] temp_zone,
    output logic [3:0] rail_en_out,
    output logic [23:0] rail_code_out,
    output logic ship_req,
    output logic [1:0] wdog_cfg_out
);
    // refuse counts that the 16-bit counters or the 32-bit long-press product cannot hold
    if (DEGLITCH_CYC < 2 || DEGLITCH_CYC > 32'h0001_0000 || TICK_CYC < 2 || TICK_CYC > 32'h0001_0000 ||
        TICKS_PER_UNIT < 1 || TICKS_PER_UNIT > 32'h0FFF_FFFF) begin : g_bad_counts
        $error("pmcb_top: counts out of range");
    end

    // two-stage synchronisers for the pins
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
        end else begin
            sync1_r <= {mode_pin_hi, mode_pin_lo, button_n};
            sync2_r <= sync1_r;
        end
    end
    logic btn_s;
    assign btn_s = sync2_r[0];

    // deglitch: button must stay low for the whole filter time
    logic [15:0] dg_cnt_r;
    logic btn_filt_r;
    logic fall_r;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dg_cnt_r <= 16'h0000;
            btn_filt_r <= 1'b1;
            fall_r <= 1'b0;
        end else begin
            fall_r <= 1'b0;
            if (btn_s == btn_filt_r) begin
                dg_cnt_r <= 16'h0000;
            end else if (dg_cnt_r == 16'(DEGLITCH_CYC - 1)) begin
                dg_cnt_r <= 16'h0000;
                btn_filt_r <= btn_s;
                fall_r <= !btn_s;
            end else begin
                dg_cnt_r <= dg_cnt_r + 16'h0001;
            end
        end
    end
    // a fall in the middle of sequencing is dropped, not deferred
    logic fall_ok;
    assign fall_ok = fall_r && !seq_busy;

    // slow tick from the system clock
    logic [15:0] tick_cnt_r;
    logic tick_r;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (tick_cnt_r == 16'(TICK_CYC - 1));
            tick_cnt_r <= (tick_cnt_r == 16'(TICK_CYC - 1)) ? 16'h0000 : tick_cnt_r + 16'h0001;
        end
    end

    // long-press state machine; counts ticks while filtered level stays low
    pmcb_btn_t lp_st_r;
    logic [31:0] lp_cnt_r;
    logic [31:0] lp_limit;
    logic [4:0] rst_cnt_r;
    assign lp_limit = 32'(TICKS_PER_UNIT) * (32'(long_press_duration) + 32'h1);
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lp_st_r <= PMCB_ST_IDLE;
            lp_cnt_r <= 32'h0;
            rst_cnt_r <= 5'h00;
        end else begin
            case (lp_st_r)
                PMCB_ST_IDLE: begin
                    lp_cnt_r <= 32'h0;
                    if (!btn_filt_r) begin
                        lp_st_r <= PMCB_ST_LOW;
                    end
                end
                PMCB_ST_LOW: begin
                    if (btn_filt_r) begin
                        lp_st_r <= PMCB_ST_IDLE;
                    end else if (lp_cnt_r >= lp_limit) begin
                        lp_st_r <= PMCB_ST_RESET;
                        rst_cnt_r <= 5'h00;
                    end else if (tick_r) begin
                        lp_cnt_r <= lp_cnt_r + 32'h1;
                    end
                end
                PMCB_ST_RESET: begin
                    // hold the request at least a fixed time so the sequencer sees it, then until release; the count
                    // stops at its end so a late release does not wait for a wrap
                    if (rst_cnt_r != 5'(`PMCB_RST_PULSE_CYC - 1)) begin
                        rst_cnt_r <= rst_cnt_r + 5'h01;
                    end else if (btn_filt_r) begin
                        lp_st_r <= PMCB_ST_IDLE;
                    end
                end
                default: begin
                    lp_st_r <= PMCB_ST_IDLE;
                end
            endcase
        end
    end
    logic lp_reset;
    assign lp_reset = (lp_st_r == PMCB_ST_RESET);

    // mode selection from button, pins or host
    logic [1:0] mode_r;
    logic pin_en0_r;
    logic pins_active;
    assign pins_active = (mode_r == `PMCB_MODE_DEFAULT) ? pin_en0_r : 1'b0;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= `PMCB_MODE_DEFAULT;
        end else if (lp_reset) begin
            mode_r <= `PMCB_MODE_DEFAULT;
        end else if (fall_ok && in_ship_mode) begin
            mode_r <= `PMCB_MODE_DEFAULT;
        end else if (fall_ok && button_return_cfg[mode_r]) begin
            mode_r <= `PMCB_MODE_DEFAULT;
        end else if (pins_active) begin
            mode_r <= sync2_r[2:1];
        end else if (host_mode_wr) begin
            mode_r <= host_mode_sel;
        end
    end

    // pin select enable of mode 0; the button clear wins over a host write
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pin_en0_r <= 1'b0;
        end else if (fall_ok || lp_reset) begin
            pin_en0_r <= 1'b0;
        end else if (pin_sel_en_wr) begin
            pin_en0_r <= pin_sel_en_wdata;
        end
    end

    // register the active mode's settings
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rail_en_out <= 4'h0;
            rail_code_out <= 24'h000000;
            ship_req <= 1'b0;
            wdog_cfg_out <= 2'h0;
        end else begin
            rail_en_out <= mode_rail_en[mode_r*4 +: 4];
            rail_code_out <= mode_rail_code[mode_r*24 +: 24];
            ship_req <= mode_ship_en[mode_r];
            wdog_cfg_out <= mode_wdog_cfg[mode_r*2 +: 2];
        end
    end

    // supply path decode and prewarn event edge
    logic warn_d_r;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            source_path <= `PMCB_SRC_RESET;
            prewarn_level <= 2'h0;
            warn_d_r <= 1'b0;
            prewarn_event <= 1'b0;
        end else begin
            source_path <= lp_reset ? `PMCB_SRC_RESET : supply_source_select;
            prewarn_level <= supply_prewarn_threshold;
            warn_d_r <= supply_below_warn;
            prewarn_event <= supply_below_warn && !warn_d_r;
        end
    end

    // temperature zones and charge control
    pmcb_zone_t zone;
    always_comb begin
        if (ts_above_hot) begin
            zone = PMCB_ZONE_HOT;
        end else if (ts_below_cold) begin
            zone = PMCB_ZONE_COLD;
        end else if (ts_below_cool) begin
            zone = PMCB_ZONE_COOL;
        end else if (ts_above_warm) begin
            zone = PMCB_ZONE_WARM;
        end else begin
            zone = PMCB_ZONE_NORMAL;
        end
    end
    logic ext_zone;
    assign ext_zone = thermistor_monitor_enable && (zone == PMCB_ZONE_HOT || zone == PMCB_ZONE_COLD);
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            temp_zone <= 3'h2;
            charge_enable <= 1'b1;
            safety_timer_run <= 1'b1;
            charge_half <= 1'b0;
            cv_effective <= 6'h00;
        end else begin
            temp_zone <= zone;
            charge_enable <= !ext_zone;
            safety_timer_run <= !ext_zone;
            charge_half <= thermistor_monitor_enable && zone == PMCB_ZONE_COOL;
            if (thermistor_monitor_enable && zone == PMCB_ZONE_WARM) begin
                // saturate rather than wrap below code zero
                cv_effective <= (cv_target_code > `PMCB_HOT_OFFSET_CODE) ?
                    cv_target_code - `PMCB_HOT_OFFSET_CODE : 6'h00;
            end else begin
                cv_effective <= cv_target_code;
            end
        end
    end

    // registered status outputs
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            active_mode <= 2'h0;
            pin_mode_select_enable <= 1'b0;
            ship_exit <= 1'b0;
            chip_reset_req <= 1'b0;
            button_valid <= 1'b0;
        end else begin
            active_mode <= mode_r;
            pin_mode_select_enable <= pins_active;
            ship_exit <= fall_ok && in_ship_mode;
            chip_reset_req <= lp_reset;
            button_valid <= fall_ok;
        end
    end

    // checks
    sequence s_fall_free;
        fall_r && !seq_busy;
    endsequence
    a_busy_fall_drop: assert property (@(posedge mclk) disable iff (!arst_n)
        fall_r && seq_busy |=> !button_valid) else $error("fall during sequencing accepted");
    a_ship_exit_mode: assert property (@(posedge mclk) disable iff (!arst_n)
        s_fall_free and in_ship_mode |=> mode_r == 2'h0 && ship_exit) else $error("ship exit wrong");
    a_pin_en_clear: assert property (@(posedge mclk) disable iff (!arst_n)
        s_fall_free |=> !pin_en0_r) else $error("pin enable not cleared");
    a_return_mode0: assert property (@(posedge mclk) disable iff (!arst_n)
        s_fall_free and button_return_cfg[mode_r] |=> mode_r == 2'h0) else $error("no return");
    a_host_ignored_pins: assert property (@(posedge mclk) disable iff (!arst_n)
        !pins_active && !fall_ok && !lp_reset && !host_mode_wr |=> $stable(mode_r)) else $error("mode moved");
    a_pin_follow: assert property (@(posedge mclk) disable iff (!arst_n)
        pins_active && !fall_ok && !lp_reset |=> mode_r == $past(sync2_r[2:1])) else $error("pins not followed");
    a_cold_hot_stop: assert property (@(posedge mclk) disable iff (!arst_n)
        ext_zone |=> !charge_enable && !safety_timer_run) else $error("charge not stopped");
    a_monitor_off: assert property (@(posedge mclk) disable iff (!arst_n)
        !thermistor_monitor_enable |=> charge_enable && !charge_half) else $error("zone active while off");
    a_cool_half: assert property (@(posedge mclk) disable iff (!arst_n)
        thermistor_monitor_enable && zone == PMCB_ZONE_COOL |=> charge_half) else $error("no half current");
    a_deglitch_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        fall_r |-> $past(btn_s, 2) == 1'b0) else $error("short glitch passed");
    a_source_decode: assert property (@(posedge mclk) disable iff (!arst_n)
        !lp_reset |=> source_path == $past(supply_source_select)) else $error("source wrong");
    a_prewarn_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
        prewarn_event |=> !prewarn_event) else $error("prewarn not a pulse");
    a_long_reset: assert property (@(posedge mclk) disable iff (!arst_n)
        lp_reset |=> chip_reset_req && source_path == 2'h0) else $error("long press reset");
endmodule : pmcb_top
`default_nettype wire

// File: pmcb_top_tb.sv
// self-checking bench for the mode and button control block
`timescale 1ns/100ps
`default_nettype none
module pmcb_top_tb;
    import pmcb_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    wire logic button_n, mode_pin_lo, mode_pin_hi;
    logic supply_below_warn = 1'b0, ts_below_cold = 1'b0, ts_below_cool = 1'b0;
    logic ts_above_warm = 1'b0, ts_above_hot = 1'b0, seq_busy = 1'b0, in_ship_mode = 1'b0;
    // longest press code keeps ordinary presses far from the long-press reset
    logic [1:0] supply_source_select = 2'h0, supply_prewarn_threshold = 2'h0, long_press_duration = 2'h3;
    logic thermistor_monitor_enable = 1'b1, host_mode_wr = 1'b0, pin_sel_en_wr = 1'b0, pin_sel_en_wdata = 1'b0;
    logic [5:0] cv_target_code = 6'h20;
    logic [1:0] host_mode_sel = 2'h0;
    logic [3:0] button_return_cfg = 4'h4, mode_ship_en = 4'h4;
    logic [15:0] mode_rail_en = 16'hC5A3;
    logic [95:0] mode_rail_code = 96'h123456_789ABC_DEF012_3C5A69;
    logic [7:0] mode_wdog_cfg = 8'hE4;
    logic [1:0] active_mode, source_path, prewarn_level, wdog_cfg_out;
    logic pin_mode_select_enable, prewarn_event, ship_exit, chip_reset_req, button_valid;
    logic charge_enable, safety_timer_run, charge_half, ship_req;
    logic [5:0] cv_effective;
    logic [2:0] temp_zone;
    logic [3:0] rail_en_out;
    logic [23:0] rail_code_out;
    int num_errors = 0;
    int num_checks = 0;
    logic ship_seen;
    // short counts keep long press and deglitch within a few dozen cycles
    pmcb_top #(.DEGLITCH_CYC(4), .TICK_CYC(4), .TICKS_PER_UNIT(2)) i_pmcb_top (
        .mclk, .arst_n, .button_n, .mode_pin_lo, .mode_pin_hi, .supply_below_warn, .ts_below_cold,
        .ts_below_cool, .ts_above_warm, .ts_above_hot, .seq_busy, .in_ship_mode, .supply_source_select,
        .supply_prewarn_threshold, .long_press_duration, .thermistor_monitor_enable, .cv_target_code,
        .host_mode_sel, .host_mode_wr, .button_return_cfg, .pin_sel_en_wr, .pin_sel_en_wdata, .mode_rail_en,
        .mode_rail_code, .mode_ship_en, .mode_wdog_cfg, .active_mode, .pin_mode_select_enable, .source_path,
        .prewarn_level, .prewarn_event, .ship_exit, .chip_reset_req, .button_valid, .charge_enable,
        .safety_timer_run, .charge_half, .cv_effective, .temp_zone, .rail_en_out, .rail_code_out, .ship_req,
        .wdog_cfg_out);
    pmcb_far_model i_pmcb_far_model (.button_n, .mode_pin_lo, .mode_pin_hi);
    // free-running 10 MHz clock
    always #50 mclk = ~mclk;
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #10;
    endtask : step
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        num_checks++;
        if (seen !== expd) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, expd);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    task automatic host_write(input logic [1:0] m);
        host_mode_sel = m;
        host_mode_wr = 1'b1;
        step(1);
        host_mode_wr = 1'b0;
        step(3);
    endtask : host_write
    // press, look for the filtered pulse, then release and let the filter settle
    task automatic press(input logic expd);
        int n = 0;
        i_pmcb_far_model.set_button(1'b1);
        while (button_valid !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        ship_seen = ship_exit;
        check(button_valid, expd);
        i_pmcb_far_model.set_button(1'b0);
        step(12);
    endtask : press
    task automatic sources_and_prewarn();
        int n = 0;
        for (int i = 0; i < 4; i++) begin
            supply_source_select = i[1:0];
            step(2);
            check(source_path, i[1:0]);
        end
        supply_prewarn_threshold = 2'h2;
        supply_below_warn = 1'b1;
        while (prewarn_event !== 1'b1 && n < 4) begin
            step(1);
            n++;
        end
        check(prewarn_event, 1'b1);
        check(prewarn_level, 2'h2);
        step(1);
        check(prewarn_event, 1'b0);
    endtask : sources_and_prewarn
    task automatic modes_and_rails();
        for (int m = 3; m >= 0; m--) begin
            host_write(m[1:0]);
            check(active_mode, m[1:0]);
            check(rail_en_out, mode_rail_en[m*4 +: 4]);
            check(rail_code_out, mode_rail_code[m*24 +: 24]);
            check(ship_req, mode_ship_en[m]);
            check(wdog_cfg_out, mode_wdog_cfg[m*2 +: 2]);
        end
        // settings of the active mode are applied live, not only on a switch
        mode_rail_en = ~mode_rail_en;
        mode_rail_code = ~mode_rail_code;
        mode_ship_en = ~mode_ship_en;
        mode_wdog_cfg = ~mode_wdog_cfg;
        step(2);
        check(rail_en_out, mode_rail_en[3:0]);
        check(rail_code_out, mode_rail_code[23:0]);
        check(ship_req, mode_ship_en[0]);
        check(wdog_cfg_out, mode_wdog_cfg[1:0]);
    endtask : modes_and_rails
    task automatic button_cases();
        logic seen = 1'b0;
        i_pmcb_far_model.set_button(1'b1);
        step(2);
        i_pmcb_far_model.set_button(1'b0);
        repeat (12) begin
            step(1);
            seen = seen | button_valid;
        end
        check(seen, 1'b0);
        host_write(2'h1);
        press(1'b1);
        check(ship_seen, 1'b0);
        check(active_mode, 2'h1);
        // return bits set for modes 1 and 2 only
        button_return_cfg = 4'h6;
        press(1'b1);
        check(active_mode, 2'h0);
        host_write(2'h2);
        seq_busy = 1'b1;
        press(1'b0);
        check(active_mode, 2'h2);
        seq_busy = 1'b0;
        host_write(2'h3);
        in_ship_mode = 1'b1;
        press(1'b1);
        check(ship_seen, 1'b1);
        check(active_mode, 2'h0);
        in_ship_mode = 1'b0;
    endtask : button_cases
    // pins follow only in mode 0 with the enable set; a filtered fall clears it
    task automatic pin_select();
        pin_sel_en_wdata = 1'b1;
        pin_sel_en_wr = 1'b1;
        step(1);
        pin_sel_en_wr = 1'b0;
        step(2);
        check(pin_mode_select_enable, 1'b1);
        host_write(2'h3);
        check(active_mode, 2'h0);
        i_pmcb_far_model.set_pins(2'h2);
        step(6);
        check(active_mode, 2'h2);
        i_pmcb_far_model.set_pins(2'h0);
        host_write(2'h0);
        press(1'b1);
        check(pin_mode_select_enable, 1'b0);
        i_pmcb_far_model.set_pins(2'h1);
        step(6);
        check(active_mode, 2'h0);
    endtask : pin_select
    task automatic zones();
        logic [3:0] cmp [5] = '{4'hC, 4'h4, 4'h0, 4'h2, 4'h3};
        for (int i = 0; i < 5; i++) begin
            {ts_below_cold, ts_below_cool, ts_above_warm, ts_above_hot} = cmp[i];
            step(2);
            check(temp_zone, i[2:0]);
            check(charge_enable, i != 0 && i != 4);
            check(safety_timer_run, i != 0 && i != 4);
            check(charge_half, i == 1);
            check(cv_effective, i == 3 ? 6'h19 : 6'h20);
        end
        // a low target saturates at code zero instead of wrapping
        {ts_below_cold, ts_below_cool, ts_above_warm, ts_above_hot} = 4'h2;
        cv_target_code = 6'h05;
        step(2);
        check(cv_effective, 6'h00);
        thermistor_monitor_enable = 1'b0;
        step(2);
        check(charge_enable, 1'b1);
        check(charge_half, 1'b0);
        check(cv_effective, 6'h05);
    endtask : zones
    // each duration code n must take 8*(n+1) cycles of filtered low, plus at most 16 cycles of sync, filter and tick delay
    task automatic long_press(input logic [1:0] code);
        int n = 0;
        long_press_duration = code;
        supply_source_select = 2'h1;
        host_write(2'h3);
        i_pmcb_far_model.set_button(1'b1);
        while (chip_reset_req !== 1'b1 && n < 200) begin
            step(1);
            n++;
        end
        if (n >= 200) begin
            num_errors++;
            print_verdict();
        end
        check(n >= 8 * (code + 1) && n <= 8 * (code + 1) + 16, 1'b1);
        step(1);
        check(active_mode, 2'h0);
        check(source_path, 2'h0);
        i_pmcb_far_model.set_button(1'b0);
        step(40);
    endtask : long_press
    initial begin
        #5000000;
        num_errors++;
        print_verdict();
    end
    initial begin
        step(4);
        arst_n = 1'b1;
        step(1);
        check(active_mode, 2'h0);
        check(source_path, 2'h0);
        check(temp_zone, 3'h2);
        sources_and_prewarn();
        modes_and_rails();
        button_cases();
        pin_select();
        zones();
        for (int c = 0; c < 4; c++) begin
            long_press(c[1:0]);
        end
        supply_source_select = 2'h2;
        arst_n = 1'b0;
        step(1);
        check(source_path, 2'h0);
        check(active_mode, 2'h0);
        print_verdict();
    end
endmodule : pmcb_top_tb
`default_nettype wire
